// file: logic/flash_gate_pkg.sv
// package: register map, field positions, reset values and memory states for the flash write gate
package flash_gate_pkg;

    // =====================================================================
    // register byte offsets (aligned words)
    // =====================================================================
    localparam logic [7:0] OFS_CONFIG    = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h0C;
    localparam logic [7:0] OFS_FLASH_CTL = 8'h10;
    localparam logic [7:0] OFS_ERASE_LO  = 8'h14;
    localparam logic [7:0] OFS_ERASE_HI  = 8'h18;
    localparam logic [7:0] OFS_BOOT_CTL  = 8'h1C;

    // =====================================================================
    // field positions
    // =====================================================================
    localparam int CFG_ROM_BRK_EN  = 0;
    localparam int CFG_TRACE_EN    = 1;
    localparam int ST_PROG_V       = 0;
    localparam int ST_BOOT_ACTIVE  = 1;
    localparam int ST_USER_RUN     = 2;
    localparam int ST_BRK_PENDING  = 3;
    localparam int ST_FLASH_BUSY   = 4;
    localparam int BOOT_DONE_BIT   = 0;
    localparam int EV_ROM_BRK      = 0;
    localparam int EV_BOOT_ENTER   = 1;
    localparam int EV_BOOT_DONE    = 2;
    localparam int EV_PV_ERASE     = 3;
    localparam int EV_BITS         = 4;

    // =====================================================================
    // reset values and sizes
    // =====================================================================
    localparam logic [31:0] CONFIG_RESET  = 32'h0000_0003;
    localparam logic [7:0]  FLASH_CTL_RST = 8'h00;
    localparam logic [7:0]  ERASE_RST     = 8'h00;
    localparam int          FLASH_AW      = 8;
    localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    // memory access states
    typedef enum logic [1:0] {
        MEM_IDLE,
        MEM_ERASE,
        MEM_DONE
    } mem_state_e;

endpackage : flash_gate_pkg

// file: logic/flash_req_if.sv
// interface: flash array request and answer between gate and memory
`timescale 1ns/1ps
interface flash_req_if;
    logic                              wr_en;
    logic                              erase_en;
    logic [flash_gate_pkg::FLASH_AW-1:0] addr;
    logic [7:0]                        wdata;
    logic [7:0]                        rdata;
    logic                              erase_busy;

    modport gate (output wr_en, output erase_en, output addr, output wdata,
                  input rdata, input erase_busy);
    modport mem  (input wr_en, input erase_en, input addr, input wdata,
                  output rdata, output erase_busy);
endinterface : flash_req_if

// file: logic/flash_store.sv
// emulation memory standing in for the flash array
`timescale 1ns/1ps
module flash_store (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // request port
    flash_req_if.mem req
);
    import flash_gate_pkg::*;

    localparam int DEPTH = 1 << FLASH_AW;

    logic [7:0]           mem [DEPTH];
    logic [FLASH_AW-1:0]  erase_ptr;
    mem_state_e           state;

    // erase walk state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state     <= MEM_IDLE;
            erase_ptr <= '0;
        end else begin
            case (state)
                MEM_IDLE: begin
                    if (req.erase_en) begin
                        state     <= MEM_ERASE;
                        erase_ptr <= '0;
                    end
                end
                MEM_ERASE: begin
                    erase_ptr <= erase_ptr + 1'b1;
                    if (&erase_ptr) begin
                        state <= MEM_DONE;
                    end
                end
                MEM_DONE: state <= MEM_IDLE;
                default:  state <= MEM_IDLE;
            endcase
        end
    end

    // array update: single write programs the byte fully
    always_ff @(posedge aclk) begin
        if (state == MEM_ERASE) begin
            mem[erase_ptr] <= ERASED_BYTE;
        end else if (req.wr_en) begin
            mem[req.addr] <= req.wdata;
        end
    end

    assign req.rdata      = mem[req.addr];
    assign req.erase_busy = (state != MEM_IDLE);

endmodule : flash_store

// file: logic/emulated_flash_write_gate.sv
// main file: flash write gate with boot-mode entry, break holding and trace gating
//
// Behaviour
// - with voltage present, writes store except during an erase walk, no break
// - without voltage, writes dropped, break if enabled
// - one write fully programs the byte
// - erase only while voltage is present
// - control and erase-select registers have no effect
// - inverted data stored exactly as written
// - no protection mode ever blocks writes
// - target reset with both pins high enters boot
// - emulator reset never enters boot
// - break_out held during boot, rom_break not; emulator reset aborts
// - boot bus cycles hidden from trace
// - no error flags during write or erase
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module emulated_flash_write_gate (
    // clock and reset
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    // target pins (asynchronous)
    input  wire logic                            prog_voltage_in,
    input  wire logic                            boot_mode_pin,
    input  wire logic                            target_reset_n,
    // cpu bus cycles into the flash region
    input  wire logic                            cpu_wr,
    input  wire logic                            cpu_rd,
    input  wire logic [flash_gate_pkg::FLASH_AW-1:0] cpu_addr,
    input  wire logic [7:0]                      cpu_wdata,
    input  wire logic                            cpu_erase,
    input  wire logic                            cpu_bad_access,
    output logic [7:0]                           cpu_rdata,
    // break and trace
    input  wire logic                            break_req,
    output logic                                 break_out,
    output logic                                 rom_break,
    output logic                                 trace_valid,
    output logic                                 access_error,
    // axi4-lite write address
    input  wire logic [7:0]                      s_axi_awaddr,
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]                     s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                           s_axi_bresp,
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]                      s_axi_araddr,
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    output logic [31:0]                          s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    // interrupt
    output logic                                 irq
);
    import flash_gate_pkg::*;

    // =====================================================================
    // pin synchronisers
    // =====================================================================
    logic [1:0] pv_sync;
    logic [1:0] mode_sync;
    logic [1:0] trst_sync;
    logic       prog_v;
    logic       mode_hi;
    logic       trst_n;
    logic       trst_n_d;

    // two flops per pin, plus target reset edge history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pv_sync   <= 2'b00;
            mode_sync <= 2'b00;
            trst_sync <= 2'b11;
            trst_n_d  <= 1'b1;
        end else begin
            pv_sync   <= {pv_sync[0], prog_voltage_in};
            mode_sync <= {mode_sync[0], boot_mode_pin};
            trst_sync <= {trst_sync[0], target_reset_n};
            trst_n_d  <= trst_n;  // idle high, so no false edge after reset
        end
    end
    assign prog_v  = pv_sync[1];
    assign mode_hi = mode_sync[1];
    assign trst_n  = trst_sync[1];

    // =====================================================================
    // registers
    // =====================================================================
    logic [31:0]         config_reg;
    logic [7:0]          flash_ctrl_reg;
    logic [7:0]          erase_block_sel_lo;
    logic [7:0]          erase_block_sel_hi;
    logic [EV_BITS-1:0]  irq_stat;
    logic [EV_BITS-1:0]  irq_mask;
    logic [EV_BITS-1:0]  events;
    logic                boot_active;
    logic                user_run;
    logic                brk_pending;
    logic                boot_done_wr;
    logic                flash_busy;

    // =====================================================================
    // axi4-lite slave
    // =====================================================================
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_fire;

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= OFS_BOOT_CTL);
    endfunction : mapped

    function automatic logic [7:0] byte_merge(input logic [7:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0] s);
        return s[0] ? d[7:0] : old;
    endfunction : byte_merge

    // write address and data capture, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // register writes; erase-select and control registers store only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_reg         <= CONFIG_RESET;
            irq_mask           <= '0;
            flash_ctrl_reg     <= FLASH_CTL_RST;
            erase_block_sel_lo <= ERASE_RST;
            erase_block_sel_hi <= ERASE_RST;
        end else if (wr_fire) begin
            case (aw_addr)
                OFS_CONFIG:    config_reg[1:0] <= w_strb[0] ? w_data[1:0] : config_reg[1:0];
                OFS_IRQ_MASK:  irq_mask <= w_strb[0] ? w_data[EV_BITS-1:0] : irq_mask;
                OFS_FLASH_CTL: flash_ctrl_reg <= byte_merge(flash_ctrl_reg, w_data, w_strb);
                OFS_ERASE_LO:  erase_block_sel_lo <= byte_merge(erase_block_sel_lo, w_data, w_strb);
                OFS_ERASE_HI:  erase_block_sel_hi <= byte_merge(erase_block_sel_hi, w_data, w_strb);
                default: ;
            endcase
        end
    end
    assign boot_done_wr = wr_fire && (aw_addr == OFS_BOOT_CTL) && w_strb[0]
                          && w_data[BOOT_DONE_BIT];

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                OFS_CONFIG:    s_axi_rdata <= config_reg;
                OFS_STATUS:    s_axi_rdata <= {27'h0, flash_busy, brk_pending,
                                               user_run, boot_active, prog_v};
                OFS_IRQ_STAT:  s_axi_rdata <= {28'h0, irq_stat};
                OFS_IRQ_MASK:  s_axi_rdata <= {28'h0, irq_mask};
                OFS_FLASH_CTL: s_axi_rdata <= {24'h0, flash_ctrl_reg};
                OFS_ERASE_LO:  s_axi_rdata <= {24'h0, erase_block_sel_lo};
                OFS_ERASE_HI:  s_axi_rdata <= {24'h0, erase_block_sel_hi};
                default:       s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // =====================================================================
    // flash access gate
    // =====================================================================
    flash_req_if fr ();

    // write passes unaltered when voltage present
    assign fr.wr_en    = cpu_wr && prog_v;
    assign fr.addr     = cpu_addr;
    assign fr.wdata    = cpu_wdata;
    assign fr.erase_en = cpu_erase && prog_v && !fr.erase_busy;
    assign flash_busy  = fr.erase_busy;

    flash_store u_store (
        .aclk    (aclk),
        .aresetn (aresetn),
        .req     (fr)
    );

    // read data and rom-break pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_rdata <= 8'h00;
            rom_break <= 1'b0;
        end else begin
            cpu_rdata <= fr.rdata;
            rom_break <= cpu_wr && !prog_v && config_reg[CFG_ROM_BRK_EN];
        end
    end

    // errors only outside flash programming
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            access_error <= 1'b0;
        end else begin
            access_error <= cpu_bad_access && !(prog_v || flash_busy);
        end
    end

    // =====================================================================
    // boot mode, break hold, trace
    // =====================================================================
    // entry only on target reset, never on aresetn
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boot_active <= 1'b0;
            user_run    <= 1'b0;
        end else if (!trst_n && trst_n_d && mode_hi && prog_v) begin
            boot_active <= 1'b1;
            user_run    <= 1'b1;
        end else if (boot_done_wr) begin
            boot_active <= 1'b0;
        end
    end

    // break held during boot, released after
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brk_pending <= 1'b0;
            break_out   <= 1'b0;
        end else begin
            break_out <= 1'b0;
            if (boot_active) begin
                brk_pending <= brk_pending || break_req;
            end else if (brk_pending || break_req) begin
                brk_pending <= 1'b0;
                break_out   <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trace_valid <= 1'b0;
        end else begin
            trace_valid <= (cpu_wr || cpu_rd) && !boot_active && config_reg[CFG_TRACE_EN];
        end
    end

    // =====================================================================
    // interrupts: sticky, write one to clear, set wins
    // =====================================================================
    assign events = {cpu_erase && !prog_v,
                     boot_done_wr && boot_active,
                     !trst_n && trst_n_d && mode_hi && prog_v,
                     cpu_wr && !prog_v && config_reg[CFG_ROM_BRK_EN]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= '0;
        end else begin
            if (wr_fire && aw_addr == OFS_IRQ_STAT && w_strb[0]) begin
                irq_stat <= (irq_stat & ~w_data[EV_BITS-1:0]) | events;
            end else begin
                irq_stat <= irq_stat | events;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // =====================================================================
    // assertions
    // =====================================================================
    sequence drop_wr_s;
        cpu_wr && !prog_v && config_reg[CFG_ROM_BRK_EN];
    endsequence

    rom_break_a: assert property (@(posedge aclk) disable iff (!aresetn)
        drop_wr_s |=> rom_break) else $error("missing rom break");
    no_break_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (cpu_wr && prog_v) |=> !rom_break) else $error("break with voltage");
    pulse_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rom_break |-> $past(cpu_wr && !prog_v && config_reg[CFG_ROM_BRK_EN]))
        else $error("unqualified break");
    gate_wr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (cpu_wr && prog_v && !flash_busy) |=> (cpu_addr != $past(cpu_addr))
        || (fr.rdata == $past(cpu_wdata))) else $error("write not stored");
    erase_v_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fr.erase_en |-> prog_v) else $error("erase without voltage");
    held_brk_a: assert property (@(posedge aclk) disable iff (!aresetn)
        boot_active |=> !break_out) else $error("break during boot");
    trace_hide_a: assert property (@(posedge aclk) disable iff (!aresetn)
        boot_active |=> !trace_valid) else $error("boot cycle traced");
    err_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
        prog_v |=> !access_error) else $error("error during programming");
    boot_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!trst_n && trst_n_d && mode_hi && prog_v) |=> boot_active && user_run)
        else $error("boot not entered");
    no_self_boot_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(boot_active) |-> $past(trst_n_d) && !$past(trst_n)) else $error("bad boot");

endmodule : emulated_flash_write_gate

// file: verif/target_side.sv
// target-side model: drives voltage, mode and reset pins toward the gate
`timescale 1ns/1ps
module target_side (
    // clock
    input  wire logic aclk,
    // requests from the bench
    input  wire logic want_pv,
    input  wire logic want_md,
    input  wire logic want_rst,
    // target pins
    output logic      prog_voltage_in,
    output logic      boot_mode_pin,
    output logic      target_reset_n
);
    // =====================================================================
    // pin drivers
    // =====================================================================
    // quiet pins until the bench asks for a level
    initial begin
        prog_voltage_in = 1'b0;
        boot_mode_pin   = 1'b0;
        target_reset_n  = 1'b1;
    end
    // pins follow the bench requests one clock later, reset pin driven active low
    always @(posedge aclk) begin
        prog_voltage_in <= want_pv;
        boot_mode_pin   <= want_md;
        target_reset_n  <= ~want_rst;
    end
endmodule : target_side

// file: verif/testbench.sv
// self-checking bench for the flash write gate
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
    import flash_gate_pkg::*;
    // =====================================================================
    // signals
    // =====================================================================
    logic        aclk, aresetn, want_pv, want_md, want_rst, pv, md, trst_n;
    logic        cpu_wr, cpu_rd, cpu_erase, cpu_bad, break_req, irq;
    logic [7:0]  cpu_addr, cpu_wdata, cpu_rdata, awaddr, araddr;
    logic        break_out, rom_break, trace_valid, access_error;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, resp;
    int          n_fail, n_checks, n_rb, n_bo, n_tv, n_ae, cyc, base;
    // =====================================================================
    // instances
    // =====================================================================
    target_side u_target_side (.aclk(aclk), .want_pv(want_pv), .want_md(want_md),
        .want_rst(want_rst), .prog_voltage_in(pv), .boot_mode_pin(md),
        .target_reset_n(trst_n));
    emulated_flash_write_gate u_emulated_flash_write_gate (.aclk(aclk), .aresetn(aresetn),
        .prog_voltage_in(pv), .boot_mode_pin(md), .target_reset_n(trst_n),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_erase(cpu_erase), .cpu_bad_access(cpu_bad), .cpu_rdata(cpu_rdata),
        .break_req(break_req), .break_out(break_out), .rom_break(rom_break),
        .trace_valid(trace_valid), .access_error(access_error),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
    // clock at 100 MHz
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // pulse counters and hang guard
    always @(posedge aclk) begin
        cyc++;
        if (rom_break === 1'b1) n_rb++;
        if (break_out === 1'b1) n_bo++;
        if (trace_valid === 1'b1) n_tv++;
        if (access_error === 1'b1) n_ae++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // =====================================================================
    // bus tasks
    // =====================================================================
    // axi write: both channels offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask : axw
    // axi read: data and response taken at the rvalid edge
    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axr
    // one-cycle cpu strobes, op = {break, bad, erase, rd, wr}
    task automatic cpu(input logic [4:0] op, input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        {break_req, cpu_bad, cpu_erase, cpu_rd, cpu_wr} <= op;
        cpu_addr <= a;
        cpu_wdata <= d;
        @(posedge aclk);
        {break_req, cpu_bad, cpu_erase, cpu_rd, cpu_wr} <= 5'h00;
        repeat (4) @(posedge aclk);
    endtask : cpu
    // pin levels, waited past the synchronisers
    task automatic pins(input logic p, input logic m);
        want_pv <= p;
        want_md <= m;
        repeat (6) @(posedge aclk);
    endtask : pins
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // =====================================================================
    // tests
    // =====================================================================
    initial begin
        {aresetn, want_pv, want_md, want_rst, awvalid, wvalid, bready} = 7'h00;
        {arvalid, rready, cpu_wr, cpu_rd, cpu_erase, cpu_bad, break_req} = 7'h00;
        {awaddr, araddr, cpu_addr, cpu_wdata, wdata} = 64'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        axr(OFS_CONFIG);
        `CHK("config", CONFIG_RESET, rd)
        axr(8'h20);
        `CHK("unmapped", RESP_SLVERR, resp)
        $display("test registers done");
        pins(1'b1, 1'b0);
        cpu(5'h01, 8'h03, 8'h3C);
        cpu(5'h02, 8'h03, 8'h00);
        `CHK("stored", 8'h3C, cpu_rdata)
        cpu(5'h01, 8'h03, 8'hC3);
        cpu(5'h02, 8'h03, 8'h00);
        `CHK("inverted", 8'hC3, cpu_rdata)
        cpu(5'h01, 8'h03, 8'h00);
        cpu(5'h02, 8'h03, 8'h00);
        `CHK("prewrite", 8'h00, cpu_rdata)
        `CHK("no break", 0, n_rb)
        pins(1'b0, 1'b0);
        axw(OFS_IRQ_MASK, 32'h0);
        cpu(5'h01, 8'h03, 8'h55);
        cpu(5'h02, 8'h03, 8'h00);
        `CHK("dropped", 8'h00, cpu_rdata)
        `CHK("rom break", 1, n_rb)
        axr(OFS_IRQ_STAT);
        `CHK("irq stat", 1'b1, rd[EV_ROM_BRK])
        `CHK("irq masked", 1'b0, irq)
        axw(OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge aclk);
        `CHK("irq raised", 1'b1, irq)
        axw(OFS_IRQ_STAT, 32'h1);
        `CHK("bresp", RESP_OKAY, resp)
        repeat (2) @(posedge aclk);
        `CHK("irq cleared", 1'b0, irq)
        axw(OFS_CONFIG, 32'h2);
        cpu(5'h01, 8'h03, 8'h55);
        `CHK("break off", 1, n_rb)
        cpu(5'h08, 8'h03, 8'h00);
        pins(1'b1, 1'b0);
        cpu(5'h08, 8'h03, 8'h00);
        `CHK("error flags", 1, n_ae)
        $display("test writes done");
        axw(OFS_FLASH_CTL, 32'hFF);
        axw(OFS_ERASE_LO, 32'hFF);
        axw(OFS_ERASE_HI, 32'hFF);
        axr(OFS_ERASE_LO);
        `CHK("select kept", 8'hFF, rd[7:0])
        cpu(5'h02, 8'h03, 8'h00);
        `CHK("no block erase", 8'h00, cpu_rdata)
        pins(1'b0, 1'b0);
        cpu(5'h04, 8'h00, 8'h00);
        cpu(5'h02, 8'h03, 8'h00);
        `CHK("erase refused", 8'h00, cpu_rdata)
        axr(OFS_IRQ_STAT);
        `CHK("refuse event", 1'b1, rd[EV_PV_ERASE])
        pins(1'b1, 1'b0);
        cpu(5'h04, 8'h00, 8'h00);
        for (int i = 0; i < 400; i++) begin
            axr(OFS_STATUS);
            if (rd[ST_FLASH_BUSY] === 1'b0) break;
        end
        cpu(5'h02, 8'h03, 8'h00);
        `CHK("erased", ERASED_BYTE, cpu_rdata)
        $display("test erase done");
        axw(OFS_CONFIG, 32'h3);
        pins(1'b1, 1'b1);
        want_rst <= 1'b1;
        repeat (4) @(posedge aclk);
        want_rst <= 1'b0;
        repeat (8) @(posedge aclk);
        axr(OFS_STATUS);
        `CHK("boot entry", 2'b11, rd[ST_USER_RUN:ST_BOOT_ACTIVE])
        base = n_tv;
        cpu(5'h12, 8'h03, 8'h00);
        `CHK("break held", 0, n_bo)
        `CHK("boot untraced", 0, n_tv - base)
        axw(OFS_BOOT_CTL, 32'h1);
        repeat (3) @(posedge aclk);
        `CHK("break taken", 1, n_bo)
        cpu(5'h02, 8'h03, 8'h00);
        `CHK("traced", 1, n_tv - base)
        want_rst <= 1'b1;
        repeat (4) @(posedge aclk);
        want_rst <= 1'b0;
        repeat (8) @(posedge aclk);
        axr(OFS_STATUS);
        `CHK("boot again", 1'b1, rd[ST_BOOT_ACTIVE])
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        repeat (12) @(posedge aclk);
        axr(OFS_STATUS);
        `CHK("boot aborted", 1'b0, rd[ST_BOOT_ACTIVE])
        $display("test boot done");
        tally_and_finish();
    end
endmodule : testbench
